// ### rtl/api_frame_codec.sv
// Notes on behaviour
// [R1] Heating set-point at bytes 44-45, little endian, 0x8000 means unused.
// [R2] Byte 46 is average load adjustment; 0x80 means ignored.
// [R3] Byte 47 is maximum on duty cycle; 0xFF means no limit.
// [R4] Byte 48 is event control bitmap, passed through whole.
// [R5] Checksum is 0xFF minus 8-bit sum of bytes from offset 3.
// [R6] Frame control bits 0-1 are frame type; 01 is cluster-specific.
// [R7] Frame control bit 2 flags manufacturer code present.
// [R8] Frame control bit 3 set means server-to-client direction.
// [R9] Bit 4 disables default response; bits 5-7 reserved, must be zero.
// [R10] Authenticated indicator type 0xa2, 64-bit address bytes 4-11 MSB first.
// [R11] Authenticated indicator 16-bit address at bytes 12-13, MSB first.
// [R12] Authenticated indicator status byte 14 always 0x00; checksum at 15.
// [R13] Registration status type 0xa4, same layout, caller status at 14.
// [R14] Delimiter at 0, then 16-bit length MSB first, counting payload bytes.
// [R15] Bad checksum or length drops the frame; hunt next delimiter.
`timescale 1ns/1ps
`include "api_frame_defs.svh"
module api_frame_codec
    import api_frame_pkg::*;
#(
    parameter logic [7:0] START_DELIM = `START_DELIM_DFLT,
    parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_valid,
    output logic o_lce_valid,
    output logic o_rx_drop,
    output logic [15:0] o_heat_setpoint,
    output logic o_heat_unused,
    output logic [7:0] o_load_pct,
    output logic o_load_unused,
    output logic [7:0] o_duty,
    output logic o_duty_unlimited,
    output logic [7:0] o_evt_ctrl,
    output logic [1:0] o_fc_type,
    output logic o_fc_cluster_cmd,
    output logic o_fc_mfr,
    output logic o_fc_srv_to_cli,
    output logic o_fc_no_dflt_rsp,
    input wire logic i_note_req,
    input wire logic i_note_kind,
    input wire logic [63:0] i_note_addr64,
    input wire logic [15:0] i_note_addr16,
    input wire logic [7:0] i_note_status,
    output logic o_note_busy,
    output logic [7:0] o_tx_data,
    output logic o_tx_valid,
    input wire logic i_tx_ready
);

    logic rst_meta;
    logic rst_n;

    // Reset release synchroniser
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    rx_state_e rx_state;
    logic [7:0] rx_len_hi;
    logic [7:0] rx_idx;
    logic [7:0] rx_sum;
    logic rx_ck_clr;
    logic rx_ck_add;
    logic rx_len_ok;
    logic rx_sum_ok;
    logic [7:0] cap_fc;
    logic [7:0] cap_heat_lo;
    logic [7:0] cap_heat_hi;
    logic [7:0] cap_load;
    logic [7:0] cap_duty;
    logic [7:0] cap_evt;
    logic rx_accept;
    logic rx_reject;

    // Length check
    assign rx_len_ok = ({rx_len_hi, i_rx_data} == `LCE_LEN);
    assign rx_ck_clr = i_rx_valid && (rx_state == RX_LEN_LO);
    assign rx_ck_add = i_rx_valid && ((rx_state == RX_BODY) || (rx_state == RX_CKSUM));
    // [R5] Sum check
    assign rx_sum_ok = (8'(rx_sum + i_rx_data) == `CKSUM_TARGET);
    // [R9] Reserved bits zero
    assign rx_accept = i_rx_valid && (rx_state == RX_CKSUM) && rx_sum_ok
        && (cap_fc[`FC_RSV_MSB:`FC_RSV_LSB] == 3'b000);
    // [R15] Reject bad frame
    assign rx_reject = i_rx_valid
        && (((rx_state == RX_CKSUM) && !rx_accept)
        || ((rx_state == RX_LEN_LO) && !rx_len_ok));

    cksum_acc u_rx_ck (
        .i_clk(i_clk_sys),
        .i_rst_n(rst_n),
        .i_clr(rx_ck_clr),
        .i_add(rx_ck_add),
        .i_byte(i_rx_data),
        .o_sum(rx_sum)
    );

    // [R14] Framing state machine
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_HUNT;
            rx_len_hi <= 8'h00;
            rx_idx <= 8'h00;
        end else if (i_rx_valid) begin
            case (rx_state)
                RX_HUNT: begin
                    if (i_rx_data == START_DELIM) begin
                        rx_state <= RX_LEN_HI;
                    end
                end
                RX_LEN_HI: begin
                    rx_len_hi <= i_rx_data;
                    rx_state <= RX_LEN_LO;
                end
                RX_LEN_LO: begin
                    rx_idx <= `CKSUM_FIRST_OFS;
                    // [R15] Length mismatch resync
                    rx_state <= rx_len_ok ? RX_BODY : RX_HUNT;
                end
                RX_BODY: begin
                    rx_idx <= rx_idx + 8'h01;
                    if (rx_idx == `LCE_OFS_LAST) begin
                        rx_state <= RX_CKSUM;
                    end
                end
                RX_CKSUM: begin
                    rx_state <= RX_HUNT;
                end
                default: begin
                    rx_state <= RX_HUNT;
                end
            endcase
        end
    end

    // Field capture while body streams in
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_fc <= 8'h00;
            cap_heat_lo <= 8'h00;
            cap_heat_hi <= 8'h00;
            cap_load <= 8'h00;
            cap_duty <= 8'h00;
            cap_evt <= 8'h00;
        end else if (i_rx_valid && (rx_state == RX_BODY)) begin
            case (rx_idx)
                `LCE_OFS_FC: begin
                    cap_fc <= i_rx_data;
                end
                // [R1] Set-point low byte
                `LCE_OFS_HEAT_LO: begin
                    cap_heat_lo <= i_rx_data;
                end
                `LCE_OFS_HEAT_HI: begin
                    cap_heat_hi <= i_rx_data;
                end
                // [R2] Load adjustment byte
                `LCE_OFS_LOAD: begin
                    cap_load <= i_rx_data;
                end
                // [R3] Duty cycle byte
                `LCE_OFS_DUTY: begin
                    cap_duty <= i_rx_data;
                end
                // [R4] Event control byte
                `LCE_OFS_EVT: begin
                    cap_evt <= i_rx_data;
                end
                default: begin
                    cap_fc <= cap_fc;
                end
            endcase
        end
    end

    // Publish decoded fields on good frame
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_heat_setpoint <= 16'h0000;
            o_heat_unused <= 1'b0;
            o_load_pct <= 8'h00;
            o_load_unused <= 1'b0;
            o_duty <= 8'h00;
            o_duty_unlimited <= 1'b0;
            o_evt_ctrl <= 8'h00;
        end else if (rx_accept) begin
            // [R1] Little endian assembly
            o_heat_setpoint <= {cap_heat_hi, cap_heat_lo};
            o_heat_unused <= ({cap_heat_hi, cap_heat_lo} == `HEAT_UNUSED);
            // [R2] Load ignored flag
            o_load_pct <= cap_load;
            o_load_unused <= (cap_load == `LOAD_UNUSED);
            // [R3] No limit flag
            o_duty <= cap_duty;
            o_duty_unlimited <= (cap_duty == `DUTY_NO_LIMIT);
            // [R4] Bitmap passed whole
            o_evt_ctrl <= cap_evt;
        end
    end

    // Frame control decode
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_fc_type <= 2'b00;
            o_fc_cluster_cmd <= 1'b0;
            o_fc_mfr <= 1'b0;
            o_fc_srv_to_cli <= 1'b0;
            o_fc_no_dflt_rsp <= 1'b0;
        end else if (rx_accept) begin
            // [R6] Frame type field
            o_fc_type <= cap_fc[`FC_TYPE_MSB:`FC_TYPE_LSB];
            o_fc_cluster_cmd <= (cap_fc[`FC_TYPE_MSB:`FC_TYPE_LSB] == `FC_TYPE_CLUSTER);
            // [R7] Manufacturer flag
            o_fc_mfr <= cap_fc[`FC_MFR_BIT];
            // [R8] Direction bit
            o_fc_srv_to_cli <= cap_fc[`FC_DIR_BIT];
            // [R9] Default response disable
            o_fc_no_dflt_rsp <= cap_fc[`FC_NODR_BIT];
        end
    end

    // Result pulses
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_lce_valid <= 1'b0;
            o_rx_drop <= 1'b0;
        end else begin
            o_lce_valid <= rx_accept;
            // [R15] Drop indication
            o_rx_drop <= rx_reject;
        end
    end

    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------
    tx_state_e tx_state;
    logic [3:0] tx_idx;
    logic [7:0] tx_type;
    logic [63:0] tx_addr64;
    logic [15:0] tx_addr16;
    logic [7:0] tx_status;
    logic [7:0] tx_sum;
    logic [7:0] next_tx_byte;
    logic tx_start;
    logic tx_push;
    logic tx_last;
    logic tx_ck_add;

    byte_stream_if #(.WIDTH(8)) fill_if ();
    byte_stream_if #(.WIDTH(8)) drain_if ();

    assign tx_start = i_note_req && (tx_state == TX_IDLE);
    assign tx_push = (tx_state == TX_SEND) && fill_if.ready;
    assign tx_last = tx_push && (tx_idx == `NOTE_OFS_CKSUM);
    assign tx_ck_add = tx_push && (tx_idx >= 4'(`CKSUM_FIRST_OFS))
        && (tx_idx != `NOTE_OFS_CKSUM);
    assign fill_if.valid = (tx_state == TX_SEND);
    assign fill_if.data = next_tx_byte;

    cksum_acc u_tx_ck (
        .i_clk(i_clk_sys),
        .i_rst_n(rst_n),
        .i_clr(tx_start),
        .i_add(tx_ck_add),
        .i_byte(next_tx_byte),
        .o_sum(tx_sum)
    );

    // Latch notification contents
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_type <= `NOTE_TYPE_AUTH;
            tx_addr64 <= 64'h0000_0000_0000_0000;
            tx_addr16 <= 16'h0000;
            tx_status <= `STATUS_SUCCESS;
        end else if (tx_start) begin
            tx_addr64 <= i_note_addr64;
            tx_addr16 <= i_note_addr16;
            if (i_note_kind == NOTE_REG) begin
                // [R13] Registration status frame
                tx_type <= `NOTE_TYPE_REG;
                tx_status <= i_note_status;
            end else begin
                // [R12] Status forced success
                tx_type <= `NOTE_TYPE_AUTH;
                tx_status <= `STATUS_SUCCESS;
            end
        end
    end

    // Byte selection by offset
    always_comb begin
        next_tx_byte = 8'h00;
        case (tx_idx)
            // [R14] Delimiter and length
            4'd0: next_tx_byte = START_DELIM;
            4'd1: next_tx_byte = 8'(`NOTE_LEN >> 8);
            4'd2: next_tx_byte = 8'(`NOTE_LEN);
            // [R10] Frame type byte
            `NOTE_OFS_TYPE: next_tx_byte = tx_type;
            // [R11] Short address MSB first
            `NOTE_OFS_A16_HI: next_tx_byte = tx_addr16[15:8];
            `NOTE_OFS_A16_LO: next_tx_byte = tx_addr16[7:0];
            // [R12] Status byte
            `NOTE_OFS_STATUS: next_tx_byte = tx_status;
            // [R5] Checksum generation
            `NOTE_OFS_CKSUM: next_tx_byte = `CKSUM_TARGET - tx_sum;
            default: begin
                // [R10] Long address MSB first
                next_tx_byte = tx_addr64[8'(6'd63 - {tx_idx[2:0] - 3'd4, 3'b000}) -: 8];
            end
        endcase
    end

    // Frame sequencer
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_idx <= 4'd0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_idx <= 4'd0;
                    if (tx_start) begin
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_push) begin
                        tx_idx <= tx_idx + 4'd1;
                    end
                    if (tx_last) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Busy flag
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_note_busy <= 1'b0;
        end else if (tx_start) begin
            o_note_busy <= 1'b1;
        end else if (tx_last) begin
            o_note_busy <= 1'b0;
        end
    end

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_clk(i_clk_sys),
        .i_rst_n(rst_n),
        .wr(fill_if),
        .rd(drain_if)
    );

    // Registered output stage
    assign drain_if.ready = !o_tx_valid || i_tx_ready;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
        end else if (drain_if.valid && drain_if.ready) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= drain_if.data;
        end else if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
        end
    end

endmodule

// ### rtl/api_frame_defs.svh
`ifndef API_FRAME_DEFS_SVH
`define API_FRAME_DEFS_SVH

// Frame framing
`define START_DELIM_DFLT 8'h7e
`define CKSUM_FIRST_OFS 8'd3
`define CKSUM_TARGET 8'hff

// Notification frames
`define NOTE_TYPE_AUTH 8'ha2
`define NOTE_TYPE_REG 8'ha4
`define NOTE_LEN 16'h000c
`define NOTE_OFS_TYPE 4'd3
`define NOTE_OFS_A64_FIRST 4'd4
`define NOTE_OFS_A64_LAST 4'd11
`define NOTE_OFS_A16_HI 4'd12
`define NOTE_OFS_A16_LO 4'd13
`define NOTE_OFS_STATUS 4'd14
`define NOTE_OFS_CKSUM 4'd15
`define STATUS_SUCCESS 8'h00

// Load control event frame
`define LCE_LEN 16'h002e
`define LCE_OFS_FC 8'd23
`define LCE_OFS_HEAT_LO 8'd44
`define LCE_OFS_HEAT_HI 8'd45
`define LCE_OFS_LOAD 8'd46
`define LCE_OFS_DUTY 8'd47
`define LCE_OFS_EVT 8'd48
`define LCE_OFS_LAST 8'd48
`define HEAT_UNUSED 16'h8000
`define LOAD_UNUSED 8'h80
`define DUTY_NO_LIMIT 8'hff

// Frame control byte fields
`define FC_TYPE_LSB 0
`define FC_TYPE_MSB 1
`define FC_MFR_BIT 2
`define FC_DIR_BIT 3
`define FC_NODR_BIT 4
`define FC_RSV_LSB 5
`define FC_RSV_MSB 7
`define FC_TYPE_CLUSTER 2'b01

// Buffering
`define TX_FIFO_DEPTH 4

`endif

// ### rtl/api_frame_pkg.sv
package api_frame_pkg;

    typedef enum logic [4:0] {
        RX_HUNT = 5'b00001,
        RX_LEN_HI = 5'b00010,
        RX_LEN_LO = 5'b00100,
        RX_BODY = 5'b01000,
        RX_CKSUM = 5'b10000
    } rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_e;

    typedef enum logic {
        NOTE_AUTH = 1'b0,
        NOTE_REG = 1'b1
    } note_kind_e;

endpackage

// ### rtl/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ### rtl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    byte_stream_if.snk wr,
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    assign wr.ready = (cnt != FULL_CNT);
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// ### rtl/cksum_acc.sv
`timescale 1ns/1ps
module cksum_acc (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clr,
    input wire logic i_add,
    input wire logic [7:0] i_byte,
    output logic [7:0] o_sum
);
    // Running 8-bit sum; clear restarts it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sum <= 8'h00;
        end else if (i_clr) begin
            o_sum <= 8'h00;
        end else if (i_add) begin
            o_sum <= o_sum + i_byte;
        end
    end
endmodule

// ### verification/api_frame_codec_chk.sv
`timescale 1ns/1ps
module api_frame_codec_chk (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_note_req,
    input wire logic i_tx_ready,
    input wire logic o_lce_valid,
    input wire logic o_rx_drop,
    input wire logic [15:0] o_heat_setpoint,
    input wire logic o_heat_unused,
    input wire logic [7:0] o_load_pct,
    input wire logic o_load_unused,
    input wire logic [7:0] o_duty,
    input wire logic o_duty_unlimited,
    input wire logic [7:0] o_evt_ctrl,
    input wire logic [1:0] o_fc_type,
    input wire logic o_fc_cluster_cmd,
    input wire logic o_note_busy,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_valid
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    property p_tx_hold;
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped while stalled");
    property p_first_byte;
        $rose(o_note_busy) |-> ##2 o_tx_valid;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("no byte after accept");
    property p_busy;
        i_note_req && !o_note_busy |=> o_note_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("idle request not taken");
    property p_heat_flag;
        o_lce_valid |-> o_heat_unused == (o_heat_setpoint == 16'h8000);
    endproperty
    a_heat_flag: assert property (p_heat_flag) else $error("setpoint flag wrong");
    property p_load_flag;
        o_lce_valid |-> o_load_unused == (o_load_pct == 8'h80);
    endproperty
    a_load_flag: assert property (p_load_flag) else $error("load flag wrong");
    property p_duty_flag;
        o_lce_valid |-> o_duty_unlimited == (o_duty == 8'hff);
    endproperty
    a_duty_flag: assert property (p_duty_flag) else $error("duty flag wrong");
    property p_cluster;
        o_lce_valid |-> o_fc_cluster_cmd == (o_fc_type == 2'b01);
    endproperty
    a_cluster: assert property (p_cluster) else $error("cluster flag wrong");
    property p_fields_hold;
        !o_lce_valid |-> $stable(o_heat_setpoint) && $stable(o_evt_ctrl) && $stable(o_duty);
    endproperty
    a_fields_hold: assert property (p_fields_hold) else $error("fields moved");
    property p_excl;
        not (o_lce_valid && o_rx_drop);
    endproperty
    a_excl: assert property (p_excl) else $error("accept and drop together");
    property p_lce_pulse;
        o_lce_valid |=> !o_lce_valid;
    endproperty
    a_lce_pulse: assert property (p_lce_pulse) else $error("accept pulse too long");
    c_lce: cover property (o_lce_valid);
    c_drop: cover property (o_rx_drop);
    c_stall: cover property (o_tx_valid && !i_tx_ready [*2]);
    c_busy: cover property ($rose(o_note_busy));
endmodule

bind api_frame_codec api_frame_codec_chk api_frame_codec_chk_inst (
    .i_clk_sys, .i_arst_n, .i_note_req, .i_tx_ready, .o_lce_valid, .o_rx_drop,
    .o_heat_setpoint, .o_heat_unused, .o_load_pct, .o_load_unused, .o_duty,
    .o_duty_unlimited, .o_evt_ctrl, .o_fc_type, .o_fc_cluster_cmd, .o_note_busy,
    .o_tx_data, .o_tx_valid
);

// ### verification/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_stall,
    output logic o_tx_ready,
    output logic o_got,
    output logic [7:0] o_got_data
);
    initial begin
        o_tx_ready = 1'b0;
        o_got = 1'b0;
        o_got_data = 8'h00;
    end
    always @(posedge i_clk_sys) begin
        o_got <= i_tx_valid && o_tx_ready;
        o_got_data <= i_tx_data;
        o_tx_ready <= i_stall ? ($urandom_range(3) == 0) : 1'b1;
    end
endmodule

// ### verification/tb_api_frame_codec.sv
`timescale 1ns/1ps
module tb_api_frame_codec;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_rx_data = 8'h00;
    logic i_rx_valid = 1'b0;
    logic i_note_req = 1'b0;
    logic i_note_kind = 1'b0;
    logic [63:0] i_note_addr64 = 64'h0;
    logic [15:0] i_note_addr16 = 16'h0;
    logic [7:0] i_note_status = 8'h00;
    logic i_tx_ready, stall = 1'b0, got;
    logic o_lce_valid, o_rx_drop, o_heat_unused, o_load_unused, o_duty_unlimited;
    logic o_fc_cluster_cmd, o_fc_mfr, o_fc_srv_to_cli, o_fc_no_dflt_rsp, o_note_busy, o_tx_valid;
    logic [15:0] o_heat_setpoint;
    logic [7:0] o_load_pct, o_duty, o_evt_ctrl, o_tx_data, got_data;
    logic [1:0] o_fc_type;
    logic [49:0] last_good = '0;
    logic [63:0] exp_tx[$];
    logic [63:0] exp_rx[$];
    int fails = 0;
    int total_checks = 0;
    int n;
    wire [49:0] rx_seen = {o_rx_drop, o_heat_setpoint, o_heat_unused, o_load_pct, o_load_unused,
        o_duty, o_duty_unlimited, o_evt_ctrl, o_fc_type, o_fc_cluster_cmd, o_fc_mfr,
        o_fc_srv_to_cli, o_fc_no_dflt_rsp};

    always #25 i_clk_sys = ~i_clk_sys;

    api_frame_codec api_frame_codec_inst (
        .i_clk_sys, .i_arst_n, .i_rx_data, .i_rx_valid, .o_lce_valid, .o_rx_drop,
        .o_heat_setpoint, .o_heat_unused, .o_load_pct, .o_load_unused, .o_duty,
        .o_duty_unlimited, .o_evt_ctrl, .o_fc_type, .o_fc_cluster_cmd, .o_fc_mfr,
        .o_fc_srv_to_cli, .o_fc_no_dflt_rsp, .i_note_req, .i_note_kind, .i_note_addr64,
        .i_note_addr16, .i_note_status, .o_note_busy, .o_tx_data, .o_tx_valid, .i_tx_ready
    );
    host_model host_model_inst (
        .i_clk_sys, .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .i_stall(stall),
        .o_tx_ready(i_tx_ready), .o_got(got), .o_got_data(got_data)
    );

    task automatic print_verdict();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    always @(posedge i_clk_sys) begin
        if (got === 1'b1)
            check(64'(got_data), exp_tx.size() ? exp_tx.pop_front() : 'x);
        if (o_lce_valid === 1'b1 || o_rx_drop === 1'b1)
            check(64'(rx_seen), exp_rx.size() ? exp_rx.pop_front() : 'x);
    end

    task automatic send_lce(input logic [15:0] ht, input logic [7:0] ld, dt, ev, fc, input int flt);
        logic [7:0] b [0:49];
        logic [7:0] sum;
        logic [49:0] e;
        int cnt;
        b[0] = 8'h7e;
        b[1] = 8'h00;
        b[2] = (flt == 2) ? 8'h2d : 8'h2e;
        for (int i = 3; i < 49; i++)
            b[i] = 8'($urandom);
        b[23] = fc;
        b[44] = ht[7:0];
        b[45] = ht[15:8];
        b[46] = ld;
        b[47] = dt;
        b[48] = ev;
        sum = 8'h00;
        for (int i = 3; i < 49; i++)
            sum += b[i];
        b[49] = 8'hff - sum - 8'(flt == 1);
        e = {1'b0, ht, ht == 16'h8000, ld, ld == 8'h80, dt, dt == 8'hff, ev, fc[1:0],
            fc[1:0] == 2'b01, fc[2], fc[3], fc[4]};
        if (flt != 0 || fc[7:5] != 3'b000)
            e = {1'b1, last_good[48:0]};
        else
            last_good = e;
        exp_rx.push_back(64'(e));
        cnt = (flt == 2) ? 3 : 50;
        @(posedge i_clk_sys);
        // Stray byte outside a frame
        i_rx_data <= 8'h11;
        i_rx_valid <= 1'b1;
        for (int i = 0; i < cnt; i++) begin
            @(posedge i_clk_sys);
            i_rx_data <= b[i];
            i_rx_valid <= 1'b1;
            if ($urandom_range(2) == 0) begin
                @(posedge i_clk_sys);
                i_rx_valid <= 1'b0;
            end
        end
        @(posedge i_clk_sys);
        i_rx_valid <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask

    task automatic send_note(input logic k, input logic [63:0] a64, input logic [15:0] a16,
        input logic [7:0] st);
        logic [7:0] b [0:15];
        logic [7:0] sum;
        int w;
        b[0] = 8'h7e;
        b[1] = 8'h00;
        b[2] = 8'h0c;
        b[3] = k ? 8'ha4 : 8'ha2;
        for (int i = 0; i < 8; i++)
            b[4 + i] = a64[63 - 8 * i -: 8];
        b[12] = a16[15:8];
        b[13] = a16[7:0];
        b[14] = k ? st : 8'h00;
        sum = 8'h00;
        for (int i = 3; i < 15; i++)
            sum += b[i];
        b[15] = 8'hff - sum;
        for (int i = 0; i < 16; i++)
            exp_tx.push_back(64'(b[i]));
        @(posedge i_clk_sys);
        i_note_req <= 1'b1;
        i_note_kind <= k;
        i_note_addr64 <= a64;
        i_note_addr16 <= a16;
        i_note_status <= st;
        @(posedge i_clk_sys);
        // Held request while busy must be ignored
        i_note_kind <= ~k;
        i_note_addr64 <= ~a64;
        @(posedge i_clk_sys);
        i_note_req <= 1'b0;
        w = 0;
        while (o_note_busy === 1'b1 && w < 400) begin
            @(posedge i_clk_sys);
            w++;
        end
    endtask

    initial begin
        #2000000;
        fails++;
        print_verdict();
    end

    initial begin
        void'($urandom(68784));
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        send_note(1'b0, {$urandom, $urandom}, 16'($urandom), 8'h5a);
        stall <= 1'b1;
        repeat (2)
            send_note(1'b1, {$urandom, $urandom}, 16'($urandom), 8'($urandom));
        repeat (80) @(posedge i_clk_sys);
        stall <= 1'b0;
        send_lce(16'h8000, 8'h80, 8'hff, 8'h00, 8'h09, 0);
        for (int k = 0; k < 8; k++)
            send_lce(16'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                8'($urandom_range(31)), 0);
        send_lce(16'h1234, 8'h05, 8'h40, 8'h3c, 8'h29, 0);
        send_lce(16'h0abc, 8'h10, 8'h20, 8'h01, 8'h09, 1);
        send_lce(16'h0abc, 8'h10, 8'h20, 8'h01, 8'h09, 2);
        send_lce(16'h0dcb, 8'h80, 8'hff, 8'h7e, 8'h11, 0);
        n = 0;
        while ((exp_tx.size() != 0 || exp_rx.size() != 0) && n < 500) begin
            @(posedge i_clk_sys);
            n++;
        end
        check(64'(exp_tx.size() + exp_rx.size()), 64'h0);
        print_verdict();
    end
endmodule
